// >>> common/sfp_pkg.sv
// Contract
// RULE_01 - Quad enable turns pause pin into lane3
// RULE_02 - Pause freezes transfer, keeps partial sequence
// RULE_03 - Pause and select low: output high impedance
// RULE_04 - Transfer resumes where stopped after pause
// RULE_05 - Separate init pin only on dedicated build
// RULE_06 - Init input high: normal operation
// RULE_07 - Init input low: init state, outputs off
// RULE_08 - Host avoids init during internal write
// RULE_09 - Clock modes 0 and 3 need no setup; in mode 0 the output runs one bit late
// RULE_10 - Master idles clock low or high per mode
// RULE_11 - Inputs captured on serial clock rising edge
// RULE_12 - Outputs launched on serial clock falling edge
// RULE_13 - Quad mode uses lanes 0 to 3
// RULE_14 - Array in aligned 4 Kbyte sectors
// RULE_15 - Array in aligned 32/64 Kbyte blocks
// RULE_16 - Deselected: outputs off, input ignored
// RULE_17 - Select must fall before first instruction
// RULE_18 - Quad enable disables write-protect input
// RULE_19 - All fields shifted most significant first
// RULE_20 - Master selects at most one device; the bench's one select drives both builds at once
package sfp_pkg;
  // Register byte offsets on the bus
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_RXDATA = 5'h08;
  localparam logic [4:0] OFS_TXDATA = 5'h0C;
  localparam logic [4:0] OFS_ADDR   = 5'h10;
  localparam logic [4:0] OFS_SECTOR = 5'h14;
  localparam logic [4:0] OFS_BLOCK  = 5'h18;
  // Control bit positions
  localparam int CTRL_QE    = 0;
  localparam int CTRL_PFS   = 1;
  localparam int CTRL_QUAD  = 2;
  localparam int CTRL_DRIVE = 3;
  // Status bit positions
  localparam int STAT_SEL    = 0;
  localparam int STAT_PAUSED = 1;
  localparam int STAT_INIT   = 2;
  localparam int STAT_ARMED  = 3;
  localparam int STAT_RXV    = 4;
  localparam int STAT_WP     = 5;
  // Reset values and framing constants
  localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;
  localparam logic [3:0]  CTRL_RESET = 4'h0;
  localparam logic [7:0]  TX_RESET   = 8'h00;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam logic [3:0]  STEP_ONE   = 4'h1;
  localparam logic [3:0]  STEP_QUAD  = 4'h4;
  localparam logic [2:0]  ADDR_FIRST = 3'h1;
  localparam logic [2:0]  ADDR_LAST  = 3'h3;
  localparam logic [2:0]  BYTE_SAT   = 3'h4;
  localparam logic [3:0]  OE_SINGLE  = 4'h2;
  localparam logic [3:0]  OE_QUAD    = 4'hF;
  localparam logic [3:0]  OE_NONE    = 4'h0;
  // Array organisation in address bits
  localparam int SECTOR_SHIFT = 12;
  localparam int BLK32_SHIFT  = 15;
  localparam int BLK64_SHIFT  = 16;
  localparam int ADDR_W       = 24;
endpackage

// >>> src/sfp_addr_map.sv
`timescale 1ns/1ps
`default_nettype none
// Splits a byte address into sector and block indices
module sfp_addr_map
  import sfp_pkg::*;
(
  input  wire logic [ADDR_W-1:0]             addr,
  output logic      [ADDR_W-SECTOR_SHIFT-1:0] sector_idx,
  output logic      [ADDR_W-BLK32_SHIFT-1:0]  blk32_idx,
  output logic      [ADDR_W-BLK64_SHIFT-1:0]  blk64_idx,
  output logic      [ADDR_W-1:0]             sector_base
);
  // Indices are plain upper address bits; bases are size aligned
  always_comb begin
    sector_idx  = addr[ADDR_W-1:SECTOR_SHIFT];                 // [RULE_14]
    blk32_idx   = addr[ADDR_W-1:BLK32_SHIFT];                  // [RULE_15]
    blk64_idx   = addr[ADDR_W-1:BLK64_SHIFT];                  // [RULE_15]
    sector_base = {addr[ADDR_W-1:SECTOR_SHIFT], {SECTOR_SHIFT{1'b0}}};
  end
endmodule
`default_nettype wire

// >>> src/sfp_pin_if.sv
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Pin-level serial flash front end with an Avalon-MM register view
module sfp_pin_if
  import sfp_pkg::*;
#(
  parameter bit HAS_RESET_PIN = 1'b0  // Build option: separate init pin
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial pins
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        init_n,
  input  wire logic [3:0]  lane_in,
  output logic      [3:0]  lane_out,
  output logic      [3:0]  lane_oe
);
  // Whole module state
  typedef struct packed {
    logic        qe;          // quad_lane_enable
    logic        pfs;         // shared_pin_function_select
    logic        quad;        // quad_instruction_mode
    logic        drive;       // Quad lanes driven by device
    logic        sel;         // Selected and not in init
    logic        paused;      // Pause active
    logic        init;        // Init state active
    logic        armed;       // Select seen high since init
    logic        sck_q;       // Previous synced clock level
    logic [7:0]  rx_sh;       // Input shifter
    logic [3:0]  bit_cnt;     // Bits of current input byte
    logic [7:0]  rx_byte;     // Last complete byte
    logic        rx_valid;    // Sticky byte flag
    logic [2:0]  byte_cnt;    // Bytes in this frame
    logic [23:0] addr;        // Bytes 1..3 of the frame
    logic [7:0]  tx_reg;      // Byte software wants sent
    logic [7:0]  tx_sh;       // Output shifter
    logic [3:0]  out_cnt;     // Bits of current output byte
    logic [3:0]  lane_out;    // Pin drive values
    logic [3:0]  lane_oe;     // Pin enables
    logic        wait_q;      // Waitrequest level
    logic [31:0] rdata;       // Read data register
  } sfp_state_s;

  sfp_state_s st;
  sfp_state_s next_st;

  // Synchronised pins
  logic [6:0] pins_s;         // {init_n, cs_n, sck, lane3..0}
  logic       s_init_n;       // Synced dedicated init pin
  logic       s_cs_n;         // Synced select
  logic       s_sck;          // Synced serial clock
  logic [3:0] s_lane;         // Synced lanes

  // Address map outputs
  logic [11:0] sector_idx;    // 4 Kbyte sector number
  logic [8:0]  blk32_idx;     // 32 Kbyte block number
  logic [7:0]  blk64_idx;     // 64 Kbyte block number
  logic [23:0] sector_base;   // Aligned sector start

  // Combinational helpers
  logic       rise;           // Serial clock rising edge
  logic       fall;           // Serial clock falling edge
  logic       init_now;       // Init requested this cycle
  logic       hold_fn;        // Lane3 acts as pause
  logic       active;         // Transfer may advance
  logic [3:0] step;           // Bits per edge
  logic [3:0] bit_nxt;        // Input count after edge
  logic [3:0] out_nxt;        // Output count after edge
  logic [7:0] rx_new;         // Input shifter after edge
  logic       acc;            // Bus access completes this edge

  // All pins from outside pass two flops
  sfp_sync #(
    .W (7)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({init_n, cs_n, sck, lane_in}),
    .q   (pins_s)
  );

  assign s_init_n = pins_s[6];
  assign s_cs_n   = pins_s[5];
  assign s_sck    = pins_s[4];
  assign s_lane   = pins_s[3:0];

  // Sector and block indices of the captured address
  sfp_addr_map u_map (
    .addr        (st.addr),
    .sector_idx  (sector_idx),
    .blk32_idx   (blk32_idx),
    .blk64_idx   (blk64_idx),
    .sector_base (sector_base)
  );

  // Next-state logic
  always_comb begin
    next_st = st;
    // Edges of the sampled clock; in mode 0 no fall precedes the first rise, so output runs one bit late
    rise = s_sck && !st.sck_q;                                 // [RULE_09]
    fall = !s_sck && st.sck_q;                                 // [RULE_09]
    next_st.sck_q = s_sck;

    // Lane3 is data under quad enable, else pause or init
    if (HAS_RESET_PIN) begin
      // Dedicated pin: function select is ignored
      init_now = !s_init_n;                                    // [RULE_05]
      hold_fn  = !st.qe;                                       // [RULE_01]
    end else begin
      init_now = !st.qe && st.pfs && !s_lane[3];               // [RULE_01]
      hold_fn  = !st.qe && !st.pfs;                            // [RULE_01]
    end

    // Selection, init and pause levels
    next_st.init   = init_now;                                 // [RULE_07]
    next_st.sel    = !s_cs_n && !init_now;                     // [RULE_06] [RULE_16]
    next_st.paused = next_st.sel && hold_fn && !s_lane[3];     // [RULE_02]
    if (init_now) begin
      next_st.armed = 1'b0;                                    // [RULE_07]
    end else if (s_cs_n) begin
      next_st.armed = 1'b1;                                    // [RULE_17]
    end

    step   = st.quad ? STEP_QUAD : STEP_ONE;                   // [RULE_13]
    active = next_st.sel && !next_st.paused && st.armed;       // [RULE_04]

    // Bus access: first cycle raises the answer, second completes
    acc = (avs_read || avs_write) && !st.wait_q;
    if ((avs_read || avs_write) && st.wait_q) begin
      next_st.wait_q = 1'b0;
      case (avs_address)
        OFS_CTRL: begin
          next_st.rdata = {28'h000_0000, st.drive, st.quad, st.pfs, st.qe};
        end
        OFS_STATUS: begin
          next_st.rdata = DATA_ZERO;
          next_st.rdata[STAT_SEL]    = st.sel;
          next_st.rdata[STAT_PAUSED] = st.paused;
          next_st.rdata[STAT_INIT]   = st.init;
          next_st.rdata[STAT_ARMED]  = st.armed;
          next_st.rdata[STAT_RXV]    = st.rx_valid;
          next_st.rdata[STAT_WP]     = !st.qe && !s_lane[2];   // [RULE_18]
        end
        OFS_RXDATA: begin
          next_st.rdata = {24'h00_0000, st.rx_byte};
        end
        OFS_TXDATA: begin
          next_st.rdata = {24'h00_0000, st.tx_reg};
        end
        OFS_ADDR: begin
          next_st.rdata = {8'h00, st.addr};
        end
        OFS_SECTOR: begin
          next_st.rdata = {8'h00, sector_base[23:12], 12'h000};
          next_st.rdata[11:0] = sector_idx;                    // [RULE_14]
        end
        OFS_BLOCK: begin
          next_st.rdata = {7'h00, blk32_idx, 8'h00, blk64_idx}; // [RULE_15]
        end
        default: begin
          next_st.rdata = DATA_ZERO;                           // Unmapped reads zero
        end
      endcase
    end else if (acc) begin
      next_st.wait_q = 1'b1;
    end

    // Writes and read side effects take place as the answer is taken
    if (acc && avs_write && avs_byteenable[0]) begin
      if (avs_address == OFS_CTRL) begin
        next_st.qe    = avs_writedata[CTRL_QE];
        next_st.pfs   = avs_writedata[CTRL_PFS];
        next_st.quad  = avs_writedata[CTRL_QUAD];
        next_st.drive = avs_writedata[CTRL_DRIVE];
      end else if (avs_address == OFS_TXDATA) begin
        next_st.tx_reg = avs_writedata[7:0];
      end
    end
    if (acc && avs_read && avs_address == OFS_RXDATA) begin
      next_st.rx_valid = 1'b0;                                 // Cleared by reading
    end

    // Input shifting, most significant first
    bit_nxt = st.bit_cnt + step;
    out_nxt = st.out_cnt + step;
    if (st.quad) begin
      rx_new = {st.rx_sh[3:0], s_lane};                        // [RULE_13] [RULE_19]
    end else begin
      rx_new = {st.rx_sh[6:0], s_lane[0]};                     // [RULE_19]
    end

    if (!next_st.sel) begin
      // Deselected or init: frame state dropped, inputs ignored
      next_st.bit_cnt = 4'h0;                                  // [RULE_16]
      next_st.out_cnt = 4'h0;
      next_st.byte_cnt = 3'h0;
      next_st.tx_sh   = st.tx_reg;
    end else if (active) begin
      if (rise) begin
        next_st.rx_sh = rx_new;                                // [RULE_11]
        if (bit_nxt == BYTE_BITS) begin
          next_st.bit_cnt  = 4'h0;
          next_st.rx_byte  = rx_new;
          next_st.rx_valid = 1'b1;                             // Set beats clear
          if (st.byte_cnt >= ADDR_FIRST && st.byte_cnt <= ADDR_LAST) begin
            next_st.addr = {st.addr[15:0], rx_new};            // [RULE_19]
          end
          if (st.byte_cnt != BYTE_SAT) begin
            next_st.byte_cnt = st.byte_cnt + 3'h1;
          end
        end else begin
          next_st.bit_cnt = bit_nxt;
        end
      end
      if (fall) begin
        // Launch the next bit or nibble
        if (st.quad) begin
          next_st.lane_out = st.tx_sh[7:4];                    // [RULE_12] [RULE_13]
        end else begin
          next_st.lane_out = {2'b00, st.tx_sh[7], 1'b0};       // [RULE_12]
        end
        if (out_nxt == BYTE_BITS) begin
          next_st.out_cnt = 4'h0;
          next_st.tx_sh   = st.tx_reg;
        end else begin
          next_st.out_cnt = out_nxt;
          next_st.tx_sh   = st.tx_sh << step;
        end
      end
    end
    // Paused: counters and shifters are left as they stand [RULE_02]

    // Output enables follow the registered pin states
    if (!next_st.sel || next_st.paused || !st.armed) begin
      next_st.lane_oe = OE_NONE;                               // [RULE_03] [RULE_07] [RULE_16]
    end else if (st.quad) begin
      next_st.lane_oe = st.drive ? OE_QUAD : OE_NONE;          // [RULE_13]
    end else begin
      next_st.lane_oe = OE_SINGLE;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.sck_q    <= 1'b1;  // Same level as the synchroniser after reset
      st.qe       <= CTRL_RESET[CTRL_QE];
      st.pfs      <= CTRL_RESET[CTRL_PFS];
      st.quad     <= CTRL_RESET[CTRL_QUAD];
      st.drive    <= CTRL_RESET[CTRL_DRIVE];
      st.tx_reg   <= TX_RESET;
      st.tx_sh    <= TX_RESET;
      st.wait_q   <= 1'b1;
      st.rdata    <= DATA_ZERO;
      st.lane_oe  <= OE_NONE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = st.wait_q;
  assign lane_out        = st.lane_out;
  assign lane_oe         = st.lane_oe;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_paused_edge;
    st.paused && (s_sck != st.sck_q);
  endsequence

  sequence s_good_rise;
    !st.quad && st.sel && !st.paused && st.armed && s_sck && !st.sck_q;
  endsequence

  property p_quad_no_pause;
    st.qe |-> !st.paused;
  endproperty
  a_quad_no_pause: assert property (p_quad_no_pause) // [RULE_01]
    else $error("pause active under quad enable");

  property p_pause_freeze;
    s_paused_edge ##1 st.paused |-> $stable(st.bit_cnt) && $stable(st.rx_sh);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze) // [RULE_02]
    else $error("shift state moved during pause");

  property p_pause_hiz;
    st.paused |-> lane_oe == OE_NONE;
  endproperty
  a_pause_hiz: assert property (p_pause_hiz) // [RULE_03]
    else $error("lane driven during pause");

  property p_resume;
    st.paused ##1 !st.paused && st.sel |-> st.bit_cnt == $past(st.bit_cnt, 2);
  endproperty
  a_resume: assert property (p_resume) // [RULE_04]
    else $error("count lost across pause");

  property p_init_hiz;
    st.init |-> lane_oe == OE_NONE && !st.sel && !st.armed;
  endproperty
  a_init_hiz: assert property (p_init_hiz) // [RULE_07]
    else $error("outputs enabled in init state");

  property p_rise_capture;
    s_good_rise |=> st.rx_sh[0] == $past(s_lane[0]);
  endproperty
  a_rise_capture: assert property (p_rise_capture) // [RULE_11]
    else $error("input bit not captured on rise");

  property p_fall_launch;
    st.sel ##1 (lane_out != $past(lane_out)) |-> $past(fall) || !$past(st.sel);
  endproperty
  a_fall_launch: assert property (p_fall_launch) // [RULE_12]
    else $error("output changed without falling edge");

  property p_desel_hiz;
    !st.sel |-> lane_oe == OE_NONE ##1 st.bit_cnt == 4'h0;
  endproperty
  a_desel_hiz: assert property (p_desel_hiz) // [RULE_16]
    else $error("deselected device drives or counts");

  property p_unarmed_idle;
    !st.armed && st.sel |=> $stable(st.rx_valid) || !$past(st.rx_valid) && !st.rx_valid;
  endproperty
  a_unarmed_idle: assert property (p_unarmed_idle) // [RULE_17]
    else $error("byte taken before select fell");

  property p_sector_align;
    sector_base[11:0] == 12'h000 && blk64_idx == st.addr[23:16];
  endproperty
  a_sector_align: assert property (p_sector_align) // [RULE_14] [RULE_15]
    else $error("sector or block misaligned");
endmodule
`default_nettype wire

// >>> src/sfp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for pins from outside the clock domain
module sfp_sync
  import sfp_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] ff1;  // Metastability catcher, read by ff2 only
    logic [W-1:0] ff2;  // Safe copy
  } sfp_sync_s;

  sfp_sync_s st;
  sfp_sync_s next_st;

  // Shift the pins through the chain
  always_comb begin
    next_st.ff1 = d;
    next_st.ff2 = st.ff1;
  end

  // Pins idle high, so the chain resets to ones
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.ff2;
endmodule
`default_nettype wire

// >>> tb/sfp_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural master owning serial clock, select and the pin levels
module sfp_spi_master
  import sfp_pkg::*;
(
  input  wire logic [3:0] lane_pin,
  input  wire logic       clk,
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] lane_drv,
  output logic      [3:0] lane_den
);
  logic       idle_lvl;  // Clock level between frames
  logic       hold_lvl;  // Level on the shared pause pin
  logic       wp_lvl;    // Level on the protect pin
  logic [7:0] rx;        // Bits sampled on lane1

  // Idle pins at time zero
  initial begin
    idle_lvl = 1'b0;
    hold_lvl = 1'b1;
    wp_lvl   = 1'b1;
    sck      = 1'b0;
    cs_n     = 1'b1;
    lane_drv = 4'hF;
    lane_den = 4'hD;
    rx       = 8'h00;
  end

  // Sets pause and protect pin levels
  task automatic pins(input logic hold, input logic wp);
    hold_lvl = hold;
    wp_lvl = wp;
    lane_drv <= {hold, wp, 2'b11};
  endtask

  // Parks the clock at the mode idle level, then selects
  task automatic select(input logic mode3);
    idle_lvl = mode3;
    sck <= mode3;  // Idle level per mode
    repeat (13) @(posedge clk);
    cs_n <= 1'b0;  // Select falls from high; both builds share this select
    repeat (13) @(posedge clk);
  endtask

  // Shifts n steps of tx, one bit or one nibble a step
  task automatic shift(input logic [7:0] tx, input int n, input logic quad);
    logic [7:0] d;
    d = tx;
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      lane_den <= quad ? 4'hF : 4'hD;
      if (quad) begin
        lane_drv <= d[7:4];  // High nibble first
        d = d << 4;
      end else begin
        lane_drv <= {hold_lvl, wp_lvl, 1'b1, d[7]};  // Most significant first
        d = d << 1;
      end
      repeat (12) @(posedge clk);
      sck <= 1'b1;
      rx = {rx[6:0], lane_pin[1]};  // Sample output at the rising edge
      repeat (13) @(posedge clk);
    end
  endtask

  // Returns clock to idle and ends the frame
  task automatic deselect();
    sck <= idle_lvl;
    repeat (13) @(posedge clk);
    cs_n <= 1'b1;
    lane_den <= 4'hD;
    lane_drv <= {hold_lvl, wp_lvl, 2'b11};
    repeat (13) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the serial flash pin front end
module testbench
  import sfp_pkg::*;
;
  logic        clk;
  logic        rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sck;
  logic        cs_n;
  logic        init_n;
  wire  [3:0]  lane_in;   // Resolved pin levels
  logic [3:0]  lane_out;
  logic [3:0]  lane_oe;
  logic [3:0]  lane_drv;  // Master drive values
  logic [3:0]  lane_den;  // Master drive enables
  logic [3:0]  rp_oe;     // Enables of the dedicated-pin build
  logic        flip = 1'b0;  // Changing level on undriven pins
  int          mismatches;
  int          tests_run;

  // Clock of 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Undriven lines change every cycle
  always @(posedge clk) flip <= ~flip;

  // Wire level from the enables of u_dut and the master
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign lane_in[i] = lane_oe[i] ? lane_out[i] : (lane_den[i] ? lane_drv[i] : flip);
  end

  sfp_pin_if #(.HAS_RESET_PIN(1'b0)) u_dut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sck(sck), .cs_n(cs_n), .init_n(init_n),
    .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe)
  );

  // Dedicated-pin build listening on the same pins; it never drives them
  sfp_pin_if #(.HAS_RESET_PIN(1'b1)) u_dut_rp (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(), .avs_waitrequest(),
    .sck(sck), .cs_n(cs_n), .init_n(init_n), .lane_in(lane_in), .lane_out(),
    .lane_oe(rp_oe)
  );

  sfp_spi_master u_master (
    .lane_pin(lane_in), .clk(clk), .sck(sck), .cs_n(cs_n),
    .lane_drv(lane_drv), .lane_den(lane_den)
  );

  // Prints counts and verdict, then stops
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares a value seen with the value expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    logic late;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    late = (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
    if (late) begin
      mismatches++;
      $display("Error at %0t: bus access timed out", $time);
      tally_and_finish();
    end
  endtask

  // Register write
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask

  // Register read compared under a mask
  task automatic expect_reg(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    check(v & m, e);
  endtask

  // Lets pin changes pass the synchronisers
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  // Reset values and refused accesses
  task automatic t_reset();
    expect_reg(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    check(32'(lane_oe), 32'h0000_0000);  // Deselected pins released
    avs_byteenable <= 4'hE;
    wr(OFS_CTRL, 32'h0000_000F);
    avs_byteenable <= 4'hF;
    expect_reg(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(5'h1C, 32'h0000_00FF);
    expect_reg(5'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_000A);
    expect_reg(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_000A);
    wr(OFS_CTRL, 32'h0000_0000);
    $display("t_reset done");
  endtask

  // Clocking while deselected is ignored
  task automatic t_deselect();
    u_master.shift(8'h5A, 8, 1'b0);
    expect_reg(OFS_STATUS, 32'h0000_0010, 32'h0000_0000);  // No byte taken
    check(32'(lane_oe), 32'h0000_0000);
    $display("t_deselect done");
  endtask

  // One byte each way in clock modes 0 and 3
  task automatic t_modes();
    for (int m = 0; m < 2; m++) begin
      wr(OFS_TXDATA, 32'h0000_00A5);
      u_master.select(m[0]);
      u_master.shift(8'h3C, 8, 1'b0);
      check(32'(lane_oe), 32'(OE_SINGLE));  // Output lane driven
      u_master.deselect();
      expect_reg(OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
      expect_reg(OFS_RXDATA, 32'h0000_00FF, 32'h0000_003C);
      expect_reg(OFS_STATUS, 32'h0000_0010, 32'h0000_0000);  // Read clears valid
      if (m == 1) begin
        check(32'(u_master.rx), 32'h0000_00A5);
      end else begin
        check(32'(u_master.rx[6:0]), 32'h0000_0052);  // Late first bit
      end
    end
    $display("t_modes done");
  endtask

  // Pause in mid byte, clocks ignored, then resume
  task automatic t_pause();
    u_master.select(1'b1);
    u_master.shift(8'h96, 4, 1'b0);
    u_master.pins(1'b0, 1'b1);
    settle();
    expect_reg(OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
    check(32'(lane_oe[1]), 32'h0000_0000);
    u_master.shift(8'h00, 4, 1'b0);
    u_master.pins(1'b1, 1'b1);
    settle();
    u_master.shift(8'h60, 4, 1'b0);
    u_master.deselect();
    expect_reg(OFS_RXDATA, 32'h0000_00FF, 32'h0000_0096);
    $display("t_pause done");
  endtask

  // Quad lanes, pause pin as data, protect input off
  task automatic t_quad();
    wr(OFS_CTRL, 32'h0000_0005);
    u_master.pins(1'b1, 1'b0);
    settle();
    expect_reg(OFS_STATUS, 32'h0000_0020, 32'h0000_0000);
    u_master.select(1'b1);
    u_master.shift(8'hC3, 2, 1'b1);
    u_master.deselect();
    expect_reg(OFS_RXDATA, 32'h0000_00FF, 32'h0000_00C3);
    wr(OFS_CTRL, 32'h0000_0000);
    settle();
    expect_reg(OFS_STATUS, 32'h0000_0020, 32'h0000_0020);  // Protect active again
    u_master.pins(1'b1, 1'b1);
    $display("t_quad done");
  endtask

  // Init through the separate pin of the dedicated build, then the shared pin
  task automatic t_init();
    wr(OFS_CTRL, 32'h0000_0002);
    u_master.select(1'b1);
    u_master.shift(8'hF0, 4, 1'b0);
    check(32'(rp_oe), 32'(OE_SINGLE));  // Dedicated build runs with pin high
    init_n <= 1'b0;
    settle();
    expect_reg(OFS_STATUS, 32'h0000_0004, 32'h0000_0000);
    check(32'(rp_oe), 32'h0000_0000);  // Dedicated build enters init
    init_n <= 1'b1;
    u_master.pins(1'b0, 1'b1);  // No internal write is running
    settle();
    expect_reg(OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
    check(32'(lane_oe), 32'h0000_0000);
    u_master.pins(1'b1, 1'b1);
    settle();
    expect_reg(OFS_STATUS, 32'h0000_000D, 32'h0000_0001);  // Selected, not armed
    u_master.deselect();
    expect_reg(OFS_STATUS, 32'h0000_0004, 32'h0000_0000);
    u_master.select(1'b1);
    u_master.shift(8'h81, 8, 1'b0);
    u_master.deselect();
    expect_reg(OFS_RXDATA, 32'h0000_00FF, 32'h0000_0081);
    wr(OFS_CTRL, 32'h0000_0000);
    $display("t_init done");
  endtask

  // Address frame split into sector and block numbers
  task automatic t_map();
    logic [23:0] a;
    for (int i = 0; i < 2; i++) begin
      a = i ? 24'hFF_FFFF : 24'h01_F7A3;
      u_master.select(1'b1);
      u_master.shift(8'h20, 8, 1'b0);
      u_master.shift(a[23:16], 8, 1'b0);
      u_master.shift(a[15:8], 8, 1'b0);
      u_master.shift(a[7:0], 8, 1'b0);
      u_master.deselect();
      expect_reg(OFS_ADDR, 32'h00FF_FFFF, {8'h00, a});
      expect_reg(OFS_SECTOR, 32'hFFFF_FFFF, {8'h00, a[23:12], a[23:12]});
      expect_reg(OFS_BLOCK, 32'hFFFF_FFFF, {7'h00, a[23:15], 8'h00, a[23:16]});
    end
    $display("t_map done");
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    init_n = 1'b1;
    mismatches = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_deselect();
    t_modes();
    t_pause();
    t_quad();
    t_init();
    t_map();
    tally_and_finish();
  end
endmodule
`default_nettype wire
